/* File: pkg/sfrp_map.vh */
// Purpose: Constants of the serial flash read path: opcodes, classes, lane modes, dummy counts.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef SFRP_MAP_VH
`define SFRP_MAP_VH

// ----------------------------------------
// Read opcodes, single edge rate
// ----------------------------------------
`define SFRP_OP_READ      8'h03
`define SFRP_OP_FAST      8'h0b
`define SFRP_OP_DOUT      8'h3b
`define SFRP_OP_DIO       8'hbb
`define SFRP_OP_QOUT      8'h6b
`define SFRP_OP_QIO       8'heb

// ----------------------------------------
// Read opcodes, double edge rate
// ----------------------------------------
`define SFRP_OP_FAST_DE   8'h0d
`define SFRP_OP_DOUT_DE   8'h3d
`define SFRP_OP_DIO_DE    8'hbd
`define SFRP_OP_QOUT_DE   8'h6d
`define SFRP_OP_QIO_DE    8'hed

// ----------------------------------------
// Dedicated 4-byte address read opcodes
// ----------------------------------------
`define SFRP_OP_READ4     8'h13
`define SFRP_OP_FAST4     8'h0c
`define SFRP_OP_DOUT4     8'h3c
`define SFRP_OP_DIO4      8'hbc
`define SFRP_OP_QOUT4     8'h6c
`define SFRP_OP_QIO4      8'hec

// ----------------------------------------
// Command classes and protocols
// ----------------------------------------
`define SFRP_CLS_READ     3'h0
`define SFRP_CLS_FAST     3'h1
`define SFRP_CLS_DOUT     3'h2
`define SFRP_CLS_DIO      3'h3
`define SFRP_CLS_QOUT     3'h4
`define SFRP_CLS_QIO      3'h5
`define SFRP_PROTO_EXT    2'h0
`define SFRP_PROTO_DUAL   2'h1
`define SFRP_PROTO_QUAD   2'h2

// ----------------------------------------
// Phase selectors and bit counts
// ----------------------------------------
`define SFRP_PH_OPC       2'h0
`define SFRP_PH_ADDR      2'h1
`define SFRP_PH_DATA      2'h2
`define SFRP_OPC_BITS     6'h08
`define SFRP_ADDR3_BITS   6'h18
`define SFRP_ADDR4_BITS   6'h20

// ----------------------------------------
// Dummy clock cycles and the underrun data byte
// ----------------------------------------
`define SFRP_DUM_NONE     5'h00
`define SFRP_DUM_QIO      5'h09
`define SFRP_DUM_QOUT     5'h07
`define SFRP_DUM_DOUT     5'h08
`define SFRP_DUM_DIO      5'h07
`define SFRP_DUM_FAST_EXT 5'h08
`define SFRP_DUM_FAST_DUAL 5'h07
`define SFRP_DUM_FAST_QUAD 5'h09
`define SFRP_UNDERRUN     8'hff

`endif

/* File: verilog/sfrp_pair_buffer.v */
// Purpose: Two-entry byte buffer between array fetches and the serial shifter.
// Assumes: Single clock; flush empties it in one cycle.
// Notes: Full and empty are exact; a push while full is refused by inReady.
`timescale 1ns/100ps

module sfrp_pair_buffer (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire flush,
  // Filling side
  input wire inValid,
  output wire inReady,
  input wire [7:0] inData,
  // Draining side
  output wire outValid,
  input wire outReady,
  output wire [7:0] outData
);

  reg [7:0] mem [0:1];
  reg wrPtr_r;
  reg rdPtr_r;
  reg [1:0] count_r;
  wire push;
  wire pop;

  assign inReady = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData = mem[rdPtr_r];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else if (flush) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_r <= ~wrPtr_r;
      end
      if (pop) begin
        rdPtr_r <= ~rdPtr_r;
      end
      if (push & ~pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop & ~push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule

/* File: verilog/sfrp_read_path.v */
// Purpose: Device-side read command path of a serial NOR flash.
// Assumes: Serial clock, select and lanes come from pins and are sampled by clk.
// Notes: Array bytes are fetched through a request port and staged in a two-entry buffer.
`timescale 1ns/100ps
`include "sfrp_map.vh"

// What this block does
// - Out of reset, array addresses are three bytes, bits 23 down to 0, unless the nvAddr4 strap is set.
// - Four-byte addressing is chosen by the strap or by enter and exit pulses.
// - In three-byte mode the extended address byte supplies address bits 31 to 24.
// - Select low, opcode, then three address bytes are taken before data returns.
// - Address bits are captured on rising serial clock edges, and on falling edges too for double-edge opcodes.
// - Reading starts at any byte and the address advances by one per byte.
// - Select high ends the read at once and releases the data lanes.
// - Single-edge and double-edge read opcodes are decoded; plain read has no double form.
// - Extended protocol uses lane zero for opcode, lanes per command for address and data.
// - Dual and quad protocols accept only their three reads, all phases on their lanes.
// - A command behaves alike in every protocol; lane counts and the fast read dummy count differ.
// - Fast reads wait dummy clock cycles between address and first data bit.
// - A four-byte read takes four address bytes and then behaves like a three-byte read.
// - Opcodes 13h, 0Ch, 3Ch, BCh, 6Ch, ECh always take four address bytes.
// - The four-byte fast read adds dummy cycles after the address.
// - Quad input/output read waits nine dummy cycles on single edge.
module sfrp_read_path (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Serial link pins
  input wire selectN,
  input wire serialClk,
  input wire [3:0] ioLanesIn,
  output reg [3:0] ioLanesOut,
  output reg [3:0] ioLanesOe,
  // Configuration
  input wire [1:0] protoSel,
  input wire nvAddr4,
  input wire enterAddr4,
  input wire exitAddr4,
  input wire [7:0] extAddr,
  output reg addr4Mode,
  // Array fetch port
  output reg rdReq,
  output reg [31:0] rdAddr,
  input wire rdValid,
  input wire [7:0] rdData
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_OPC = 6'h02;
  localparam [5:0] ST_ADDR = 6'h04;
  localparam [5:0] ST_DUMMY = 6'h08;
  localparam [5:0] ST_DATA = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Decode returns {accepted, doubleEdge, fourByte, class}.
  function [5:0] decodeOp;
    input [7:0] op;
    begin
      case (op)
        `SFRP_OP_READ: decodeOp = {3'b100, `SFRP_CLS_READ};
        `SFRP_OP_FAST: decodeOp = {3'b100, `SFRP_CLS_FAST};
        `SFRP_OP_DOUT: decodeOp = {3'b100, `SFRP_CLS_DOUT};
        `SFRP_OP_DIO: decodeOp = {3'b100, `SFRP_CLS_DIO};
        `SFRP_OP_QOUT: decodeOp = {3'b100, `SFRP_CLS_QOUT};
        `SFRP_OP_QIO: decodeOp = {3'b100, `SFRP_CLS_QIO};
        `SFRP_OP_FAST_DE: decodeOp = {3'b110, `SFRP_CLS_FAST};
        `SFRP_OP_DOUT_DE: decodeOp = {3'b110, `SFRP_CLS_DOUT};
        `SFRP_OP_DIO_DE: decodeOp = {3'b110, `SFRP_CLS_DIO};
        `SFRP_OP_QOUT_DE: decodeOp = {3'b110, `SFRP_CLS_QOUT};
        `SFRP_OP_QIO_DE: decodeOp = {3'b110, `SFRP_CLS_QIO};
        `SFRP_OP_READ4: decodeOp = {3'b101, `SFRP_CLS_READ};
        `SFRP_OP_FAST4: decodeOp = {3'b101, `SFRP_CLS_FAST};
        `SFRP_OP_DOUT4: decodeOp = {3'b101, `SFRP_CLS_DOUT};
        `SFRP_OP_DIO4: decodeOp = {3'b101, `SFRP_CLS_DIO};
        `SFRP_OP_QOUT4: decodeOp = {3'b101, `SFRP_CLS_QOUT};
        `SFRP_OP_QIO4: decodeOp = {3'b101, `SFRP_CLS_QIO};
        default: decodeOp = 6'h00;
      endcase
    end
  endfunction

  function protoOk;
    input [2:0] cls;
    input [1:0] proto;
    begin
      case (proto)
        `SFRP_PROTO_EXT: protoOk = 1'b1;
        `SFRP_PROTO_DUAL: protoOk = (cls == `SFRP_CLS_FAST) | (cls == `SFRP_CLS_DOUT) | (cls == `SFRP_CLS_DIO);
        `SFRP_PROTO_QUAD: protoOk = (cls == `SFRP_CLS_FAST) | (cls == `SFRP_CLS_QOUT) | (cls == `SFRP_CLS_QIO);
        default: protoOk = 1'b0;
      endcase
    end
  endfunction

  // Lane count as log2: 0 is one lane, 1 is two, 2 is four.
  function [1:0] laneLog;
    input [1:0] phase;
    input [2:0] cls;
    input [1:0] proto;
    begin
      if (proto != `SFRP_PROTO_EXT) begin
        laneLog = proto;
      end else if (phase == `SFRP_PH_OPC) begin
        laneLog = 2'h0;
      end else if (phase == `SFRP_PH_ADDR) begin
        laneLog = (cls == `SFRP_CLS_DIO) ? 2'h1 : ((cls == `SFRP_CLS_QIO) ? 2'h2 : 2'h0);
      end else if (cls == `SFRP_CLS_READ || cls == `SFRP_CLS_FAST) begin
        laneLog = 2'h0;
      end else begin
        laneLog = (cls == `SFRP_CLS_DOUT || cls == `SFRP_CLS_DIO) ? 2'h1 : 2'h2;
      end
    end
  endfunction

  function [4:0] dummyOf;
    input [2:0] cls;
    input [1:0] proto;
    begin
      case (cls)
        `SFRP_CLS_READ: dummyOf = `SFRP_DUM_NONE;
        `SFRP_CLS_FAST: dummyOf = (proto == `SFRP_PROTO_DUAL) ? `SFRP_DUM_FAST_DUAL :
                                  ((proto == `SFRP_PROTO_QUAD) ? `SFRP_DUM_FAST_QUAD : `SFRP_DUM_FAST_EXT);
        `SFRP_CLS_DOUT: dummyOf = `SFRP_DUM_DOUT;
        `SFRP_CLS_DIO: dummyOf = `SFRP_DUM_DIO;
        `SFRP_CLS_QOUT: dummyOf = `SFRP_DUM_QOUT;
        `SFRP_CLS_QIO: dummyOf = `SFRP_DUM_QIO;
        default: dummyOf = `SFRP_DUM_NONE;
      endcase
    end
  endfunction

  function [5:0] stepOf;
    input [1:0] lw;
    begin
      stepOf = (lw == 2'h0) ? 6'h01 : ((lw == 2'h1) ? 6'h02 : 6'h04);
    end
  endfunction

  function [31:0] shiftIn;
    input [31:0] sh;
    input [3:0] io;
    input [1:0] lw;
    begin
      case (lw)
        2'h0: shiftIn = {sh[30:0], io[0]};
        2'h1: shiftIn = {sh[29:0], io[1:0]};
        default: shiftIn = {sh[27:0], io[3:0]};
      endcase
    end
  endfunction

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  reg sclkMeta_r, sclkSync_r, sclkPrev_r;
  reg selMeta_r, selSync_r;
  reg [3:0] ioMeta_r, ioSync_r;
  reg [5:0] st_r;
  reg [31:0] sh_r;
  reg [5:0] cnt_r;
  reg [2:0] cls_r;
  reg [1:0] proto_r;
  reg dual_r;
  reg wide_r;
  reg [4:0] dummy_r;
  reg [7:0] outSh_r;
  reg [5:0] outCnt_r;
  reg [31:0] fetchAddr_r;
  reg fetchOn_r;
  reg pend_r;
  reg discard_r;
  reg strapDone_r;
  reg pop_r;
  wire rise, fall, addrEdge, dataEdge;
  wire [1:0] lwOpc, lwAddr, lwData;
  wire [5:0] stepOpc, stepAddr, stepData, addrBits;
  wire [31:0] shNext;
  wire [5:0] opDec;
  wire [31:0] startAddr;
  wire [7:0] byteNow;
  wire bufInReady, bufOutValid;
  wire [7:0] bufOutData;
  wire pushByte;

  assign rise = sclkSync_r & ~sclkPrev_r;
  assign fall = ~sclkSync_r & sclkPrev_r;
  assign addrEdge = rise | (dual_r & fall & (cnt_r != 6'h00));
  assign dataEdge = fall | (dual_r & rise);
  assign lwOpc = laneLog(`SFRP_PH_OPC, cls_r, proto_r);
  assign lwAddr = laneLog(`SFRP_PH_ADDR, cls_r, proto_r);
  assign lwData = laneLog(`SFRP_PH_DATA, cls_r, proto_r);
  assign stepOpc = stepOf(lwOpc);
  assign stepAddr = stepOf(lwAddr);
  assign stepData = stepOf(lwData);
  assign addrBits = wide_r ? `SFRP_ADDR4_BITS : `SFRP_ADDR3_BITS;
  assign shNext = shiftIn(sh_r, ioSync_r, (st_r == ST_OPC) ? lwOpc : lwAddr);
  assign opDec = decodeOp(shNext[7:0]);
  assign startAddr = wide_r ? shNext : {extAddr, shNext[23:0]};
  assign byteNow = bufOutValid ? bufOutData : `SFRP_UNDERRUN;
  assign pushByte = rdValid & pend_r & ~discard_r;

  sfrp_pair_buffer uBuf (
    .clk(clk),
    .rst(rst),
    .flush(selSync_r),
    .inValid(pushByte),
    .inReady(bufInReady),
    .inData(rdData),
    .outValid(bufOutValid),
    .outReady(pop_r),
    .outData(bufOutData)
  );

  // ----------------------------------------
  // Pin synchronisers and address mode
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkMeta_r <= 1'b0;
      sclkSync_r <= 1'b0;
      sclkPrev_r <= 1'b0;
      selMeta_r <= 1'b1;
      selSync_r <= 1'b1;
      ioMeta_r <= 4'h0;
      ioSync_r <= 4'h0;
      addr4Mode <= 1'b0;
      strapDone_r <= 1'b0;
    end else begin
      sclkMeta_r <= serialClk;
      sclkSync_r <= sclkMeta_r;
      sclkPrev_r <= sclkSync_r;
      selMeta_r <= selectN;
      selSync_r <= selMeta_r;
      ioMeta_r <= ioLanesIn;
      ioSync_r <= ioMeta_r;
      strapDone_r <= 1'b1;
      if (!strapDone_r) begin
        addr4Mode <= nvAddr4;
      end else if (exitAddr4) begin
        addr4Mode <= 1'b0;
      end else if (enterAddr4) begin
        addr4Mode <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Command sequencer and data shifter
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      sh_r <= 32'h0;
      cnt_r <= 6'h00;
      cls_r <= `SFRP_CLS_READ;
      proto_r <= `SFRP_PROTO_EXT;
      dual_r <= 1'b0;
      wide_r <= 1'b0;
      dummy_r <= 5'h00;
      outSh_r <= 8'h00;
      outCnt_r <= 6'h00;
      ioLanesOut <= 4'h0;
      ioLanesOe <= 4'h0;
      fetchOn_r <= 1'b0;
      fetchAddr_r <= 32'h0;
      pop_r <= 1'b0;
    end else begin
      pop_r <= 1'b0;
      if (selSync_r) begin
        st_r <= ST_IDLE;
        ioLanesOe <= 4'h0;
        fetchOn_r <= 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: begin
            st_r <= ST_OPC;
            cnt_r <= 6'h00;
            cls_r <= `SFRP_CLS_READ;
            proto_r <= protoSel;
            dual_r <= 1'b0;
          end
          ST_OPC: begin
            if (rise) begin
              sh_r <= shNext;
              cnt_r <= cnt_r + stepOpc;
              if (cnt_r + stepOpc == `SFRP_OPC_BITS) begin
                cnt_r <= 6'h00;
                if (opDec[5] && protoOk(opDec[2:0], proto_r)) begin
                  st_r <= ST_ADDR;
                  cls_r <= opDec[2:0];
                  dual_r <= opDec[4];
                  wide_r <= opDec[3] | addr4Mode;
                  dummy_r <= dummyOf(opDec[2:0], proto_r);
                end else begin
                  st_r <= ST_SKIP;
                end
              end
            end
          end
          ST_ADDR: begin
            if (addrEdge) begin
              sh_r <= shNext;
              cnt_r <= cnt_r + stepAddr;
              if (cnt_r + stepAddr == addrBits) begin
                fetchAddr_r <= startAddr;
                fetchOn_r <= 1'b1;
                outCnt_r <= 6'h00;
                st_r <= (dummy_r == 5'h00) ? ST_DATA : ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            if (rise) begin
              dummy_r <= dummy_r - 5'h01;
              if (dummy_r == 5'h01) begin
                st_r <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (dataEdge) begin
              ioLanesOe <= (lwData == 2'h0) ? 4'h2 : ((lwData == 2'h1) ? 4'h3 : 4'hf);
              if (outCnt_r == 6'h00) begin
                pop_r <= bufOutValid;
                outSh_r <= byteNow << stepData;
                outCnt_r <= 6'h08 - stepData;
                ioLanesOut <= (lwData == 2'h0) ? {2'h0, byteNow[7], 1'b0} :
                              ((lwData == 2'h1) ? {2'h0, byteNow[7:6]} : byteNow[7:4]);
              end else begin
                outSh_r <= outSh_r << stepData;
                outCnt_r <= outCnt_r - stepData;
                ioLanesOut <= (lwData == 2'h0) ? {2'h0, outSh_r[7], 1'b0} :
                              ((lwData == 2'h1) ? {2'h0, outSh_r[7:6]} : outSh_r[7:4]);
              end
            end
          end
          ST_SKIP: begin
            ioLanesOe <= 4'h0;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
      if (rdReq) begin
        fetchAddr_r <= fetchAddr_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Array fetch with one request in flight
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdReq <= 1'b0;
      rdAddr <= 32'h0;
      pend_r <= 1'b0;
      discard_r <= 1'b0;
    end else begin
      rdReq <= 1'b0;
      if (rdValid) begin
        pend_r <= 1'b0;
        discard_r <= 1'b0;
      end else if (selSync_r && pend_r) begin
        discard_r <= 1'b1;
      end
      if (fetchOn_r && !selSync_r && !pend_r && !rdReq && bufInReady) begin
        rdReq <= 1'b1;
        rdAddr <= fetchAddr_r;
        pend_r <= 1'b1;
      end
    end
  end

endmodule

/* File: sim/sfrp_read_path_asserts.sv */
// Purpose: Port-level checks of the serial flash read path.
// Assumes: Bound to sfrp_read_path; select and lanes pass two-flop synchronisers.
// Notes: Latencies are in clk cycles.
`timescale 1ns/100ps
module sfrp_read_path_asserts (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Link pins
  input wire selectN,
  input wire serialClk,
  input wire [3:0] ioLanesIn,
  input wire [3:0] ioLanesOut,
  input wire [3:0] ioLanesOe,
  // Configuration
  input wire [1:0] protoSel,
  input wire nvAddr4,
  input wire enterAddr4,
  input wire exitAddr4,
  input wire [7:0] extAddr,
  input wire addr4Mode,
  // Fetch port
  input wire rdReq,
  input wire [31:0] rdAddr,
  input wire rdValid,
  input wire [7:0] rdData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg [31:0] lastA_r;
  reg haveA_r;
  // Remembers the previous fetch address while the frame lasts.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lastA_r <= 32'h0;
      haveA_r <= 1'b0;
    end else begin
      if (rdReq) lastA_r <= rdAddr;
      haveA_r <= selectN ? 1'b0 : (haveA_r | rdReq);
    end
  end
  chk_reset_idle: assert property ($fell(rst) |-> ioLanesOe == 4'h0 && !rdReq)
    else $error("lanes or fetch active after reset");
  chk_strap_load: assert property ($fell(rst) |=> addr4Mode == $past(nvAddr4))
    else $error("address mode did not load the strap");
  chk_mode_enter: assert property (enterAddr4 && !exitAddr4 |=> addr4Mode)
    else $error("enter pulse did not set four-byte mode");
  chk_mode_exit: assert property (exitAddr4 |=> !addr4Mode)
    else $error("exit pulse did not clear four-byte mode");
  chk_mode_hold: assert property (!enterAddr4 && !exitAddr4 && !$past(rst) |=> $stable(addr4Mode))
    else $error("address mode changed without a pulse");
  chk_release_sel: assert property ($rose(selectN) |-> ##[1:5] ioLanesOe == 4'h0)
    else $error("lanes still driven after select high");
  chk_oe_selected: assert property (ioLanesOe != 4'h0 |-> !$past(selectN, 6))
    else $error("lanes driven outside a frame");
  chk_oe_shape: assert property (ioLanesOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable pattern");
  chk_req_gap: assert property (rdReq |=> !rdReq)
    else $error("fetch requests back to back");
  chk_addr_step: assert property (rdReq && haveA_r |-> rdAddr == lastA_r + 32'h1)
    else $error("fetch address did not advance by one");
  cover property (ioLanesOe == 4'hf);
  cover property ($rose(selectN) && ioLanesOe != 4'h0);
  cover property (rdReq && addr4Mode);
endmodule

bind sfrp_read_path sfrp_read_path_asserts chk (
  .clk(clk), .rst(rst), .selectN(selectN), .serialClk(serialClk), .ioLanesIn(ioLanesIn),
  .ioLanesOut(ioLanesOut), .ioLanesOe(ioLanesOe), .protoSel(protoSel), .nvAddr4(nvAddr4),
  .enterAddr4(enterAddr4), .exitAddr4(exitAddr4), .extAddr(extAddr), .addr4Mode(addr4Mode),
  .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData)
);

/* File: sim/sfrp_host_model.sv */
// Purpose: Host controller that runs read frames on the serial link.
// Assumes: Clock idles low; lanes change 20 ns after a serial edge.
// Notes: Released lanes show the inverse of their last value.
`timescale 1ns/100ps
module sfrp_host_model (
  // Clock
  input wire clk,
  // Link as seen by the host
  input wire [3:0] ioSeen,
  input wire [3:0] devOe,
  output reg selectN,
  output reg serialClk,
  output reg [3:0] hostLanes
);
  reg [7:0] got [0:7];
  reg [7:0] sh;
  reg sawOe;
  reg early;
  initial begin
    selectN = 1'b1;
    serialClk = 1'b0;
    hostLanes = 4'h5;
    sawOe = 1'b0;
    early = 1'b0;
    sh = 8'h00;
  end
  function [3:0] lm(input integer w);
    lm = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : (w == 1) ? 4'h1 : 4'h0;
  endfunction
  task put(input [3:0] v, input integer w);
    hostLanes <= #20 ((~hostLanes & ~lm(w)) | (v & lm(w)));
  endtask
  // Rise 13 cycles after a fall, fall 12 after a rise: a 125 ns period.
  task tick(input cap, input integer w);
    begin
      repeat (serialClk ? 12 : 13) @(negedge clk);
      if (devOe != 4'h0) sawOe = 1'b1;
      if (cap) sh = (w == 1) ? {sh[6:0], ioSeen[1]} : (sh << w) | (ioSeen & lm(w));
      serialClk = ~serialClk;
    end
  endtask
  task frame(input [7:0] op, input integer ol, input [31:0] a, input integer ab, input integer al,
    input integer dum, input integer dl, input de, input integer nc);
    integer i;
    begin
      sawOe = 1'b0;
      selectN = 1'b0;
      for (i = 8 / ol - 1; i >= 0; i = i - 1) begin
        put(op >> (i * ol), ol);
        tick(1'b0, 0);
        tick(1'b0, 0);
      end
      for (i = ab / al - 1; i >= 0; i = i - 1) begin
        put(a >> (i * al), al);
        tick(1'b0, 0);
        if (!de) tick(1'b0, 0);
      end
      put(4'h0, 0);
      for (i = 0; i < dum; i = i + 1) begin
        tick(1'b0, 0);
        tick(1'b0, 0);
      end
      early = sawOe;
      for (i = 0; i < nc; i = i + 1) begin
        tick(1'b1, dl);
        if (!de) tick(1'b0, 0);
        if ((i + 1) % (8 / dl) == 0) got[(i + 1) / (8 / dl) - 1] = sh;
      end
      if (serialClk) tick(1'b0, 0);
      repeat (6) @(negedge clk);
      selectN = 1'b1;
      put(4'h0, 0);
      repeat (30) @(negedge clk);
    end
  endtask
endmodule

/* File: sim/tb_serial_flash_read_path.sv */
// Purpose: Self-checking bench of the serial flash read path.
// Assumes: Array bytes are a pattern of their address; inputs change on falling clk.
// Notes: The fetch responder answers after lat cycles.
`timescale 1ns/100ps
`include "sfrp_map.vh"
module tb_serial_flash_read_path;
  reg clk, rst, nvAddr4, enterAddr4, exitAddr4, rdValid;
  reg [1:0] protoSel;
  reg [7:0] extAddr, rdData;
  reg [31:0] pa;
  wire selectN, serialClk, addr4Mode, rdReq;
  wire [3:0] hostLanes, ioLanesOut, ioLanesOe, lanes;
  wire [31:0] rdAddr;
  integer mismatches, checks, wt, lat;
  // Each lane carries the device value while enabled, else the host value.
  assign lanes = (ioLanesOe & ioLanesOut) | (~ioLanesOe & hostLanes);
  sfrp_read_path dut (
    .clk(clk), .rst(rst), .selectN(selectN), .serialClk(serialClk), .ioLanesIn(lanes),
    .ioLanesOut(ioLanesOut), .ioLanesOe(ioLanesOe), .protoSel(protoSel), .nvAddr4(nvAddr4),
    .enterAddr4(enterAddr4), .exitAddr4(exitAddr4), .extAddr(extAddr), .addr4Mode(addr4Mode),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData)
  );
  sfrp_host_model host (
    .clk(clk), .ioSeen(lanes), .devOe(ioLanesOe), .selectN(selectN), .serialClk(serialClk),
    .hostLanes(hostLanes)
  );
  function [7:0] pat(input [31:0] a);
    pat = a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h5a;
  endfunction
  always @(negedge clk) begin
    rdValid <= 1'b0;
    if (rdReq) begin
      pa = rdAddr;
      wt = lat;
    end else if (wt > 0) begin
      wt = wt - 1;
      if (wt == 0) begin
        rdValid <= 1'b1;
        rdData <= pat(pa);
      end
    end
  end
  task cmp(input [127:0] what, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (exp !== got) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task do_reset;
    begin
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  task rd(input [7:0] op, input integer ol, input [31:0] a, input integer ab, input integer al,
    input integer dum, input integer dl, input de, input integer nb, input [31:0] base);
    integer i;
    begin
      host.frame(op, ol, a, ab, al, dum, dl, de, nb * 8 / dl);
      cmp("early drive", 0, host.early);
      for (i = 0; i < nb; i = i + 1)
        cmp("data byte", pat(base + i), host.got[i]);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_ext_ops;
    begin
      rd(`SFRP_OP_READ, 1, 32'h00a0fe, 24, 1, 0, 1, 1'b0, 3, 32'h00a0fe);
      rd(`SFRP_OP_FAST, 1, 32'h001234, 24, 1, `SFRP_DUM_FAST_EXT, 1, 1'b0, 2, 32'h001234);
      rd(`SFRP_OP_DOUT, 1, 32'h00ff01, 24, 1, `SFRP_DUM_DOUT, 2, 1'b0, 2, 32'h00ff01);
      rd(`SFRP_OP_DIO, 1, 32'h0055aa, 24, 2, `SFRP_DUM_DIO, 2, 1'b0, 2, 32'h0055aa);
      rd(`SFRP_OP_QOUT, 1, 32'h00c3c3, 24, 1, `SFRP_DUM_QOUT, 4, 1'b0, 2, 32'h00c3c3);
      rd(`SFRP_OP_QIO, 1, 32'h00807f, 24, 4, `SFRP_DUM_QIO, 4, 1'b0, 2, 32'h00807f);
    end
  endtask
  task t_protocols;
    begin
      extAddr = 8'h11;
      lat = 20;
      protoSel = `SFRP_PROTO_DUAL;
      rd(`SFRP_OP_FAST, 2, 32'h000100, 24, 2, `SFRP_DUM_FAST_DUAL, 2, 1'b0, 2, 32'h11000100);
      rd(`SFRP_OP_DOUT, 2, 32'h000200, 24, 2, `SFRP_DUM_DOUT, 2, 1'b0, 2, 32'h11000200);
      rd(`SFRP_OP_DIO, 2, 32'h000300, 24, 2, `SFRP_DUM_DIO, 2, 1'b0, 2, 32'h11000300);
      host.frame(`SFRP_OP_QIO, 2, 32'h000100, 24, 2, 9, 2, 1'b0, 8);
      cmp("refused drive", 0, host.sawOe);
      protoSel = `SFRP_PROTO_QUAD;
      rd(`SFRP_OP_FAST, 4, 32'h000400, 24, 4, `SFRP_DUM_FAST_QUAD, 4, 1'b0, 2, 32'h11000400);
      rd(`SFRP_OP_QOUT, 4, 32'h000500, 24, 4, `SFRP_DUM_QOUT, 4, 1'b0, 2, 32'h11000500);
      rd(`SFRP_OP_QIO, 4, 32'h000600, 24, 4, `SFRP_DUM_QIO, 4, 1'b0, 2, 32'h11000600);
      host.frame(`SFRP_OP_READ, 4, 32'h000100, 24, 4, 0, 4, 1'b0, 4);
      cmp("refused drive", 0, host.sawOe);
      protoSel = `SFRP_PROTO_EXT;
      lat = 1;
    end
  endtask
  task t_addr4;
    begin
      extAddr = 8'h7e;
      rd(`SFRP_OP_READ4, 1, 32'h12345678, 32, 1, 0, 1, 1'b0, 2, 32'h12345678);
      rd(`SFRP_OP_FAST4, 1, 32'h9abcdef0, 32, 1, `SFRP_DUM_FAST_EXT, 1, 1'b0, 2, 32'h9abcdef0);
      rd(`SFRP_OP_DOUT4, 1, 32'h01020304, 32, 1, `SFRP_DUM_DOUT, 2, 1'b0, 2, 32'h01020304);
      rd(`SFRP_OP_DIO4, 1, 32'h05060708, 32, 2, `SFRP_DUM_DIO, 2, 1'b0, 2, 32'h05060708);
      rd(`SFRP_OP_QOUT4, 1, 32'ha0b0c0d0, 32, 1, `SFRP_DUM_QOUT, 4, 1'b0, 2, 32'ha0b0c0d0);
      rd(`SFRP_OP_QIO4, 1, 32'hfedcba98, 32, 4, `SFRP_DUM_QIO, 4, 1'b0, 2, 32'hfedcba98);
      enterAddr4 = 1'b1;
      @(negedge clk);
      enterAddr4 = 1'b0;
      cmp("4-byte mode", 1, addr4Mode);
      rd(`SFRP_OP_READ, 1, 32'hc0ffee00, 32, 1, 0, 1, 1'b0, 2, 32'hc0ffee00);
      enterAddr4 = 1'b1;
      exitAddr4 = 1'b1;
      @(negedge clk);
      enterAddr4 = 1'b0;
      exitAddr4 = 1'b0;
      cmp("4-byte mode", 0, addr4Mode);
      rd(`SFRP_OP_READ, 1, 32'h3c00f0, 24, 1, 0, 1, 1'b0, 2, 32'h7e3c00f0);
    end
  endtask
  task t_double_edge;
    begin
      rd(`SFRP_OP_FAST_DE, 1, 32'h00ab10, 24, 1, `SFRP_DUM_FAST_EXT, 1, 1'b1, 2, 32'h7e00ab10);
      rd(`SFRP_OP_DOUT_DE, 1, 32'h00ab20, 24, 1, `SFRP_DUM_DOUT, 2, 1'b1, 2, 32'h7e00ab20);
      rd(`SFRP_OP_DIO_DE, 1, 32'h00ab30, 24, 2, `SFRP_DUM_DIO, 2, 1'b1, 2, 32'h7e00ab30);
      rd(`SFRP_OP_QOUT_DE, 1, 32'h00ab40, 24, 1, `SFRP_DUM_QOUT, 4, 1'b1, 2, 32'h7e00ab40);
      rd(`SFRP_OP_QIO_DE, 1, 32'h00ab50, 24, 4, `SFRP_DUM_QIO, 4, 1'b1, 2, 32'h7e00ab50);
    end
  endtask
  task t_abort;
    begin
      host.frame(`SFRP_OP_READ, 1, 32'h000040, 24, 1, 0, 1, 1'b0, 11);
      cmp("aborted byte", pat(32'h7e000040), host.got[0]);
      cmp("released lanes", 0, ioLanesOe);
      rd(`SFRP_OP_READ, 1, 32'h000080, 24, 1, 0, 1, 1'b0, 1, 32'h7e000080);
    end
  endtask
  task t_strap;
    begin
      nvAddr4 = 1'b1;
      do_reset;
      cmp("4-byte mode", 1, addr4Mode);
      rd(`SFRP_OP_READ, 1, 32'h4433221f, 32, 1, 0, 1, 1'b0, 2, 32'h4433221f);
      nvAddr4 = 1'b0;
      do_reset;
      cmp("4-byte mode", 0, addr4Mode);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (95000) @(posedge clk);
    mismatches = mismatches + 1;
    $display("ERROR run time expected end seen hang");
    conclude;
  end
  initial begin
    rst = 1'b1;
    nvAddr4 = 1'b0;
    enterAddr4 = 1'b0;
    exitAddr4 = 1'b0;
    rdValid = 1'b0;
    rdData = 8'h00;
    protoSel = 2'h0;
    extAddr = 8'h00;
    mismatches = 0;
    checks = 0;
    wt = 0;
    lat = 1;
    do_reset;
    cmp("4-byte mode", 0, addr4Mode);
    t_ext_ops;
    t_protocols;
    t_addr4;
    t_double_edge;
    t_abort;
    t_strap;
    conclude;
  end
endmodule
